// >>> bench/test_monitor_special_function_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "msfc_consts.svh"

module test_monitor_special_function_ctrl
   import msfc_pkg::*;
;
   logic clock_in, sys_rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out, vid_step_fine_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, vid_a, vid_b;
   logic [31:0] temp_raw_in, temp_filt_in, limit_temp_out, fanctl_temp_out, el, ef;
   logic [127:0] volt_reading_in, volt_low_in, volt_high_in;
   logic [15:0] volt_err_out;
   logic [2:0] volt_hyst_sel_out;
   logic st1, st2, st3, st4, lut_a, lut_b;
   logic [1:0] vid_sel;
   logic [6:0] vid_val_a, vid_val_b, ev_a, ev_b;
   logic [7:0] v, vr [7];
   logic ve [7];
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;

   msfc_ctrl dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .temp_raw_in(temp_raw_in), .temp_filt_in(temp_filt_in),
      .limit_temp_out(limit_temp_out), .fanctl_temp_out(fanctl_temp_out),
      .volt_reading_in(volt_reading_in), .volt_low_in(volt_low_in),
      .volt_high_in(volt_high_in), .volt_err_out(volt_err_out),
      .volt_hyst_sel_out(volt_hyst_sel_out), .smart_tach_en_1_out(st1),
      .smart_tach_en_2_out(st2), .smart_tach_en_3_out(st3), .smart_tach_en_4_out(st4),
      .lut_pair_a_half_deg_out(lut_a), .lut_pair_b_half_deg_out(lut_b),
      .cpu_a_vid_pins_in(vid_a), .cpu_b_vid_pins_in(vid_b),
      .voltage_id_decode_sel_out(vid_sel), .cpu_a_voltage_id_value_out(vid_val_a),
      .cpu_b_voltage_id_value_out(vid_val_b), .vid_step_fine_out(vid_step_fine_out));

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // Ceiling sits far above the roughly 150 cycles the tests need
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (exp !== seen) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clock_in);
      reg_wr_in = 1'b0;
      reg_wdata_in = ~d;
   endtask : wr

   // Strobe held across one rising edge, answer looked at in the cycle after it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(posedge clock_in);
      #1;
      chk("rvalid", 1'b1, reg_rvalid_out);
      chk("rdata", exp, reg_rdata_out);
      @(negedge clock_in);
      reg_rd_in = 1'b0;
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst_in = 1'b1;
      reg_addr_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_wdata_in = 8'h00;
      temp_raw_in = 32'h44332211;
      temp_filt_in = 32'hddccbbaa;
      volt_reading_in = {16{8'h50}};
      volt_low_in = {16{8'h20}};
      volt_high_in = {16{8'h80}};
      vid_a = 8'hb5;
      vid_b = 8'h6a;
      repeat (12) @(negedge clock_in);
      chk("rvalid_rst", 1'b0, reg_rvalid_out);
      sys_rst_in = 1'b0;
      rd(`MSFC_ADDR_CTRL1, 8'h00);
      rd(`MSFC_ADDR_CTRL2, 8'h00);
      wr(`MSFC_ADDR_CTRL1, 8'hff);
      rd(`MSFC_ADDR_CTRL1, 8'h7f);
      chk("hyst_sel", 3'h7, volt_hyst_sel_out);
      wr(8'hbe, 8'hff);
      rd(8'hbe, 8'h00);
      $display("test registers done");

      for (int i = 0; i < 16; i++) begin
         // Smoothing enables live outside this block and stay clear here
         wr(`MSFC_ADDR_CTRL1, 8'(i << 3));
         repeat (3) @(negedge clock_in);
         for (int b = 0; b < 4; b++) begin
            el[b*8+:8] = i[b/2] ? temp_filt_in[b*8+:8] : temp_raw_in[b*8+:8];
            ef[b*8+:8] = i[2+b/2] ? temp_filt_in[b*8+:8] : temp_raw_in[b*8+:8];
         end
         chk("limit_temp", el, limit_temp_out);
         chk("fanctl_temp", ef, fanctl_temp_out);
      end
      $display("test temperature select done");

      for (int m = 0; m < 4; m++) begin
         v = 8'(m << 6) | (m[0] ? 8'h15 : 8'h2a);
         // No PWM runs in this bench, so smart tach may be enabled
         wr(`MSFC_ADDR_CTRL2, v);
         repeat (2) @(negedge clock_in);
         chk("smart_tach", v[3:0], {st4, st3, st2, st1});
         chk("lut_a", v[4], lut_a);
         chk("lut_b", v[5], lut_b);
         chk("vid_sel", v[7:6], vid_sel);
         ev_a = (m == 0) ? {1'b0, vid_a[5:0]} : (m == 3) ? vid_a[7:1] : vid_a[6:0];
         ev_b = (m == 0) ? {1'b0, vid_b[5:0]} : (m == 3) ? vid_b[7:1] : vid_b[6:0];
         chk("vid_a", ev_a, vid_val_a);
         chk("vid_b", ev_b, vid_val_b);
         chk("vid_fine", (m == 1 || m == 2), vid_step_fine_out);
         rd(`MSFC_ADDR_CTRL2, v);
      end
      $display("test tach lut vid done");

      // Band 20..80 with three counts of hysteresis; last step masks the channel
      wr(`MSFC_ADDR_CTRL1, 8'h03);
      vr = '{8'h81, 8'h7d, 8'h7c, 8'h1f, 8'h23, 8'h24, 8'h10};
      ve = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int k = 0; k < 7; k++) begin
         @(negedge clock_in);
         volt_reading_in[7:0] = vr[k];
         if (k == 6) begin
            volt_high_in[7:0] = 8'hff;
         end
         repeat (2) @(negedge clock_in);
         chk("volt_err", {15'h0, ve[k]}, volt_err_out);
      end
      $display("test voltage hysteresis done");
      finish_test();
   end
endmodule : test_monitor_special_function_ctrl
`default_nettype wire

// >>> logic/msfc_consts.svh
`ifndef MSFC_CONSTS_SVH
`define MSFC_CONSTS_SVH

// Register map on the management port
`define MSFC_ADDR_CTRL1 8'hbc
`define MSFC_ADDR_CTRL2 8'hbd
`define MSFC_RESET_CTRL 8'h00
`define MSFC_RD_UNMAPPED 8'h00
`define MSFC_C1_WR_MASK 8'h7f

// Control register one fields
`define MSFC_C1_HYST 2:0
`define MSFC_C1_LIM_Z1 3
`define MSFC_C1_LIM_Z2 4
`define MSFC_C1_FAN_Z1 5
`define MSFC_C1_FAN_Z2 6
`define MSFC_C1_RES 7

// Control register two fields
`define MSFC_C2_TACH 3:0
`define MSFC_C2_TACH1 0
`define MSFC_C2_TACH2 1
`define MSFC_C2_TACH3 2
`define MSFC_C2_TACH4 3
`define MSFC_C2_LUT_A 4
`define MSFC_C2_LUT_B 5
`define MSFC_C2_VID 7:6

// Voltage-ID decode modes
`define MSFC_VID_6BIT 2'h0
`define MSFC_VID_7BIT_EXT 2'h1
`define MSFC_VID_7BIT_LO 2'h2
`define MSFC_VID_7BIT_HI 2'h3

// Datapath shape
`define MSFC_ZONES 4
`define MSFC_ZONES_PER_GRP 2
`define MSFC_TW 8
`define MSFC_VCH 16
`define MSFC_VW 8
`define MSFC_VOLT_MASK 8'hff

`endif

// >>> logic/msfc_ctrl.sv
// Contract
// - The 3-bit hysteresis field of control register one applies to every voltage high and low limit check.
// - One step of the hysteresis field equals one converter count of the channel compared.
// - Bit 3 of control register one selects filtered temperature for zone 1a/1b limit compares.
// - Bit 4 of control register one selects filtered temperature for zone 2a/2b limit compares.
// - Bit 5 of control register one feeds filtered zone 1a/1b temperature to fan control.
// - Bit 6 of control register one feeds filtered zone 2a/2b temperature to fan control.
// - Bits 3:0 of control register two enable smart tach for tach inputs one to four.
// - Bit 4 of control register two sets half-degree resolution for lookup tables one and two.
// - Bit 5 of control register two sets half-degree resolution for lookup tables three and four.
// - Bits 7:6 of control register two select the voltage-ID decode for both value paths.
// - Decode modes: 00 six bits coarse, 01 seven bits fine, 10 bits 6:0, 11 bits 7:1 coarse.
`timescale 1ns/10ps
`default_nettype none
`include "msfc_consts.svh"

module msfc_ctrl
   import msfc_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Register port from the serial management engine
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Zone temperatures, bytes 1a, 1b, 2a, 2b from low to high
   input wire logic [31:0] temp_raw_in,
   input wire logic [31:0] temp_filt_in,
   output logic [31:0] limit_temp_out,
   output logic [31:0] fanctl_temp_out,
   // Voltage channels, one byte each
   input wire logic [127:0] volt_reading_in,
   input wire logic [127:0] volt_low_in,
   input wire logic [127:0] volt_high_in,
   output logic [15:0] volt_err_out,
   output logic [2:0] volt_hyst_sel_out,
   // Fan control configuration
   output logic smart_tach_en_1_out,
   output logic smart_tach_en_2_out,
   output logic smart_tach_en_3_out,
   output logic smart_tach_en_4_out,
   output logic lut_pair_a_half_deg_out,
   output logic lut_pair_b_half_deg_out,
   // Processor voltage-ID decode
   input wire logic [7:0] cpu_a_vid_pins_in,
   input wire logic [7:0] cpu_b_vid_pins_in,
   output logic [1:0] voltage_id_decode_sel_out,
   output logic [6:0] cpu_a_voltage_id_value_out,
   output logic [6:0] cpu_b_voltage_id_value_out,
   output logic vid_step_fine_out
);

   msfc_state_t state_reg;
   msfc_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // Voltage-ID decode; unused pins are forced to zero per mode
   function automatic logic [6:0] msfc_vid_decode(input logic [1:0] sel,
                                                  input logic [7:0] pins);
      logic [6:0] code;
      code = 7'h00;
      case (sel)
         `MSFC_VID_6BIT: begin
            code = {1'b0, pins[5:0]};
         end
         `MSFC_VID_7BIT_EXT: begin
            code = pins[6:0];
         end
         `MSFC_VID_7BIT_LO: begin
            code = pins[6:0];
         end
         `MSFC_VID_7BIT_HI: begin
            code = pins[7:1];
         end
         default: begin
            code = 7'h00;
         end
      endcase
      return code;
   endfunction : msfc_vid_decode

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;

      // Register writes; reserved bit 7 is masked off
      if (reg_wr_in && (reg_addr_in == `MSFC_ADDR_CTRL1)) begin
         state_next.ctrl1 = reg_wdata_in & `MSFC_C1_WR_MASK;
      end
      if (reg_wr_in && (reg_addr_in == `MSFC_ADDR_CTRL2)) begin
         state_next.ctrl2 = reg_wdata_in;
      end

      // A read in the same cycle as a write returns the old contents
      state_next.rvalid = reg_rd_in;
      state_next.rdata = state_reg.rdata;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `MSFC_ADDR_CTRL1: begin
               state_next.rdata = state_reg.ctrl1 & `MSFC_C1_WR_MASK;
            end
            `MSFC_ADDR_CTRL2: begin
               state_next.rdata = state_reg.ctrl2;
            end
            default: begin
               state_next.rdata = `MSFC_RD_UNMAPPED;
            end
         endcase
      end

      // Filter selection per zone group; the filtered input is only meaningful
      // while the smoothing enables elsewhere are kept clear
      for (int i = 0; i < `MSFC_ZONES; i++) begin
         if (i < `MSFC_ZONES_PER_GRP) begin
            state_next.limit_temp[i*`MSFC_TW +: `MSFC_TW] =
               state_reg.ctrl1[`MSFC_C1_LIM_Z1] ? temp_filt_in[i*`MSFC_TW +: `MSFC_TW]
                                                : temp_raw_in[i*`MSFC_TW +: `MSFC_TW];
            state_next.fanctl_temp[i*`MSFC_TW +: `MSFC_TW] =
               state_reg.ctrl1[`MSFC_C1_FAN_Z1] ? temp_filt_in[i*`MSFC_TW +: `MSFC_TW]
                                                : temp_raw_in[i*`MSFC_TW +: `MSFC_TW];
         end else begin
            state_next.limit_temp[i*`MSFC_TW +: `MSFC_TW] =
               state_reg.ctrl1[`MSFC_C1_LIM_Z2] ? temp_filt_in[i*`MSFC_TW +: `MSFC_TW]
                                                : temp_raw_in[i*`MSFC_TW +: `MSFC_TW];
            state_next.fanctl_temp[i*`MSFC_TW +: `MSFC_TW] =
               state_reg.ctrl1[`MSFC_C1_FAN_Z2] ? temp_filt_in[i*`MSFC_TW +: `MSFC_TW]
                                                : temp_raw_in[i*`MSFC_TW +: `MSFC_TW];
         end
      end

      // Both processors share one decode mode
      state_next.vid_a = msfc_vid_decode(state_reg.ctrl2[`MSFC_C2_VID], cpu_a_vid_pins_in);
      state_next.vid_b = msfc_vid_decode(state_reg.ctrl2[`MSFC_C2_VID], cpu_b_vid_pins_in);
      state_next.vid_fine = (state_reg.ctrl2[`MSFC_C2_VID] == `MSFC_VID_7BIT_EXT) ||
                            (state_reg.ctrl2[`MSFC_C2_VID] == `MSFC_VID_7BIT_LO);
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One hysteresis comparator per voltage channel
   genvar ch;
   generate
      for (ch = 0; ch < `MSFC_VCH; ch++) begin : g_volt
         msfc_volt_cmp u_cmp (
            .clock_in(clock_in),
            .sys_rst_in(sys_rst_in),
            .reading_in(volt_reading_in[ch*`MSFC_VW +: `MSFC_VW]),
            .low_in(volt_low_in[ch*`MSFC_VW +: `MSFC_VW]),
            .high_in(volt_high_in[ch*`MSFC_VW +: `MSFC_VW]),
            .hyst_in(state_reg.ctrl1[`MSFC_C1_HYST]),
            .err_out(volt_err_out[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   assign reg_rdata_out = state_reg.rdata;
   assign reg_rvalid_out = state_reg.rvalid;
   assign limit_temp_out = state_reg.limit_temp;
   assign fanctl_temp_out = state_reg.fanctl_temp;
   assign volt_hyst_sel_out = state_reg.ctrl1[`MSFC_C1_HYST];
   // Smart tach must not be driven at the fastest PWM rate; this block cannot
   // see the PWM setup, so keeping that safe is left to software
   assign smart_tach_en_1_out = state_reg.ctrl2[`MSFC_C2_TACH1];
   assign smart_tach_en_2_out = state_reg.ctrl2[`MSFC_C2_TACH2];
   assign smart_tach_en_3_out = state_reg.ctrl2[`MSFC_C2_TACH3];
   assign smart_tach_en_4_out = state_reg.ctrl2[`MSFC_C2_TACH4];
   assign lut_pair_a_half_deg_out = state_reg.ctrl2[`MSFC_C2_LUT_A];
   assign lut_pair_b_half_deg_out = state_reg.ctrl2[`MSFC_C2_LUT_B];
   assign voltage_id_decode_sel_out = state_reg.ctrl2[`MSFC_C2_VID];
   assign cpu_a_voltage_id_value_out = state_reg.vid_a;
   assign cpu_b_voltage_id_value_out = state_reg.vid_b;
   assign vid_step_fine_out = state_reg.vid_fine;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_wr_ctrl1;
      !sys_rst_in && reg_wr_in && (reg_addr_in == `MSFC_ADDR_CTRL1);
   endsequence

   sequence s_wr_ctrl2;
      !sys_rst_in && reg_wr_in && (reg_addr_in == `MSFC_ADDR_CTRL2);
   endsequence

   sequence s_rd_ctrl1;
      !sys_rst_in && reg_rd_in && !reg_wr_in && (reg_addr_in == `MSFC_ADDR_CTRL1);
   endsequence

   chk_res_bit_zero: assert property (s_rd_ctrl1 |=>
         reg_rvalid_out && (reg_rdata_out[`MSFC_C1_RES] == 1'b0))
      else $error("reserved bit read back nonzero");
   chk_hyst_write: assert property (s_wr_ctrl1 |=>
         volt_hyst_sel_out == $past(reg_wdata_in[`MSFC_C1_HYST]))
      else $error("hysteresis field not taken from write");
   chk_tach_write: assert property (s_wr_ctrl2 |=>
         {smart_tach_en_4_out, smart_tach_en_3_out, smart_tach_en_2_out,
          smart_tach_en_1_out} == $past(reg_wdata_in[`MSFC_C2_TACH]))
      else $error("smart tach enables not taken from write");
   chk_lut_res_write: assert property (s_wr_ctrl2 |=>
         (lut_pair_a_half_deg_out == $past(reg_wdata_in[`MSFC_C2_LUT_A])) &&
         (lut_pair_b_half_deg_out == $past(reg_wdata_in[`MSFC_C2_LUT_B])))
      else $error("lookup resolution bits not taken from write");
   chk_limit_zone_one: assert property (!sys_rst_in |=>
         limit_temp_out[15:0] == ($past(state_reg.ctrl1[`MSFC_C1_LIM_Z1]) ?
                                  $past(temp_filt_in[15:0])
                                                             : $past(temp_raw_in[15:0])))
      else $error("zone one limit temperature source wrong");
   chk_limit_zone_two: assert property (!sys_rst_in |=>
         limit_temp_out[31:16] == ($past(state_reg.ctrl1[`MSFC_C1_LIM_Z2]) ?
                                   $past(temp_filt_in[31:16])
                                                              : $past(temp_raw_in[31:16])))
      else $error("zone two limit temperature source wrong");
   chk_fan_zone_one: assert property (!sys_rst_in |=>
         fanctl_temp_out[15:0] == ($past(state_reg.ctrl1[`MSFC_C1_FAN_Z1]) ?
                                   $past(temp_filt_in[15:0])
                                                              : $past(temp_raw_in[15:0])))
      else $error("zone one fan temperature source wrong");
   chk_fan_zone_two: assert property (!sys_rst_in |=>
         fanctl_temp_out[31:16] == ($past(state_reg.ctrl1[`MSFC_C1_FAN_Z2]) ?
                                    $past(temp_filt_in[31:16])
                                                               : $past(temp_raw_in[31:16])))
      else $error("zone two fan temperature source wrong");
   chk_vid_mode_hi: assert property (!sys_rst_in &&
         (voltage_id_decode_sel_out == `MSFC_VID_7BIT_HI) |=>
         (cpu_a_voltage_id_value_out == $past(cpu_a_vid_pins_in[7:1])) && !vid_step_fine_out)
      else $error("upper seven bit decode wrong");
   chk_vid_mode_six: assert property (!sys_rst_in &&
         (voltage_id_decode_sel_out == `MSFC_VID_6BIT) |=>
         (cpu_b_voltage_id_value_out == {1'b0, $past(cpu_b_vid_pins_in[5:0])}))
      else $error("six bit decode wrong");

endmodule : msfc_ctrl
`default_nettype wire

// >>> logic/msfc_pkg.sv
`default_nettype none
package msfc_pkg;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] rdata;
      logic rvalid;
      logic [31:0] limit_temp;
      logic [31:0] fanctl_temp;
      logic [6:0] vid_a;
      logic [6:0] vid_b;
      logic vid_fine;
   } msfc_state_t;

   typedef struct packed {
      logic err;
   } msfc_cmp_state_t;

endpackage : msfc_pkg
`default_nettype wire

// >>> logic/msfc_volt_cmp.sv
`timescale 1ns/10ps
`default_nettype none
`include "msfc_consts.svh"

module msfc_volt_cmp
   import msfc_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reading_in,
   input wire logic [7:0] low_in,
   input wire logic [7:0] high_in,
   input wire logic [2:0] hyst_in,
   output logic err_out
);

   msfc_cmp_state_t state_reg;
   msfc_cmp_state_t state_next;
   logic [8:0] high_ext;
   logic [8:0] low_ext;
   logic [8:0] read_ext;
   logic [8:0] hyst_ext;
   logic over;
   logic under;
   logic clear_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Hysteresis counts raw converter steps, so widen by one bit to avoid wrap
   assign high_ext = {1'b0, high_in};
   assign low_ext = {1'b0, low_in};
   assign read_ext = {1'b0, reading_in};
   assign hyst_ext = {6'h00, hyst_in};

   assign over = (reading_in > high_in) && (high_in != `MSFC_VOLT_MASK);
   assign under = (reading_in < low_in) && (high_in != `MSFC_VOLT_MASK);
   // Removed once inside both limits by more than the hysteresis, or when the channel is masked
   assign clear_ok = ((read_ext + hyst_ext) < high_ext) &&
                     (read_ext > (low_ext + hyst_ext));

   always_comb begin
      state_next = state_reg;
      if (over || under) begin
         state_next.err = 1'b1;
      end else if (clear_ok || (high_in == `MSFC_VOLT_MASK)) begin
         state_next.err = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign err_out = state_reg.err;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_out_of_limit;
      !sys_rst_in && (over || under);
   endsequence

   sequence s_in_band;
      !sys_rst_in && err_out && !clear_ok && (high_in != `MSFC_VOLT_MASK);
   endsequence

   chk_err_set_limit: assert property (s_out_of_limit |=> err_out)
      else $error("voltage error not raised beyond a limit");
   chk_err_hold_band: assert property (s_in_band |=> err_out)
      else $error("voltage error dropped inside the hysteresis band");
   chk_err_rise_cause: assert property ($rose(err_out) |-> $past(over || under))
      else $error("voltage error raised without a limit crossing");

endmodule : msfc_volt_cmp
`default_nettype wire
